// ---- hdl/rpr_pkg.sv ----
// Shared constants, types and register map of the remappable pin router
package rpr_pkg;

	// ----------------------------------------
	// Pin and routing dimensions
	// ----------------------------------------
	localparam int NUM_BIDIR = 32;
	localparam int NUM_INONLY = 14;
	localparam int NUM_PINS = 46;
	localparam int NUM_IN = 36;
	localparam int NUM_IN_REGS = 18;
	localparam int NUM_OUT_REGS = 16;
	localparam int FLD_W = 6;
	localparam int FLD0_LSB = 0;
	localparam int FLD1_LSB = 8;
	localparam logic [5:0] MAX_PIN_SEL = 6'h2D;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [5:0] IN_SEL_RST = 6'h3F;
	localparam logic [5:0] OUT_CODE_RST = 6'h00;

	// ----------------------------------------
	// Register byte addresses (haddr[11:0])
	// ----------------------------------------
	localparam logic [11:0] IN_BASE = 12'h000;
	localparam logic [11:0] OUT_BASE = 12'h080;
	localparam logic [11:0] ALT_ADDR = 12'h0C0;
	localparam logic [11:0] OSC_ADDR = 12'h0C4;
	localparam int ALT_SPI_BIT = 0;
	localparam int LOCK_BIT = 6;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h57;

	// ----------------------------------------
	// Routed peripheral input index bases
	// ----------------------------------------
	// Within a group: ext irq 1..4, capture 1..9, fault a/b,
	// spi 1..3 as clock/data/select, timer 2..5, uart 1..4 as rx/cts.
	localparam int IN_EXT_IRQ = 0;
	localparam int IN_CAPTURE = 4;
	localparam int IN_CMP_FAULT = 13;
	localparam int IN_SPI = 15;
	localparam int IN_TIMER_CLK = 24;
	localparam int IN_UART = 28;

	// ----------------------------------------
	// Output function codes
	// ----------------------------------------
	localparam logic [5:0] CODE_NULL = 6'h00;
	localparam logic [5:0] CODE_CMP1 = 6'h01;
	localparam logic [5:0] CODE_CMP2 = 6'h02;
	localparam logic [5:0] CODE_UART_ONE_TRANSMIT = 6'h03;
	localparam logic [5:0] CODE_UART_ONE_REQUEST_SEND = 6'h04;
	localparam logic [5:0] CODE_UART_TWO_TRANSMIT = 6'h05;
	localparam logic [5:0] CODE_UART_TWO_REQUEST_SEND = 6'h06;
	localparam logic [5:0] CODE_SPI1_DO = 6'h07;
	localparam logic [5:0] CODE_SPI1_CK = 6'h08;
	localparam logic [5:0] CODE_SPI1_SS = 6'h09;
	localparam logic [5:0] CODE_SPI2_DO = 6'h0A;
	localparam logic [5:0] CODE_SPI2_CK = 6'h0B;
	localparam logic [5:0] CODE_SPI2_SS = 6'h0C;
	localparam logic [5:0] CODE_OC1 = 6'h12;

	// Routable peripheral outputs
	typedef struct packed {
		logic comparator_one_out;
		logic comparator_two_out;
		logic uart_one_transmit;
		logic uart_one_request_send;
		logic uart_two_transmit;
		logic uart_two_request_send;
		logic spi1_data_out;
		logic spi1_clock_out;
		logic spi1_select_out;
		logic spi2_data_out;
		logic spi2_clock_out;
		logic spi2_select_out;
		logic compare_output_one;
	} rpr_fout_t;

	typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} rpr_unlock_t;

endpackage : rpr_pkg

// ---- hdl/rpr_router.sv ----
// Remappable pin router: AHB-Lite register slave and pin routing logic
//
// Our own choices: the address map and the AHB-Lite interface to the registers.

// How it works
// - Bidirectional pins 0 to 31 are routed
// - Pins 32 to 45 feed inputs only
// - Six-bit select picks pin per peripheral input
// - Input route register packs two select fields
// - Output route register packs two pin codes
// - Code zero leaves pin unrouted
// - Codes 1-6 select comparators and uarts
// - Codes 7-12 spi outputs, 18 compare one
// - Thirty-six routable peripheral inputs are provided
// - Routed output beats port latch and parallel port
// - Fixed special outputs beat routed outputs
// - Routed inputs never enable the pin driver
// - Analog mode blocks routed input from pin
// - No routing until fields assign a pin
// - Input and output routing are independent
// - Alternate bit sends spi1 clock to fixed pin
// - Legal selects match implemented pin count
// - Selects above 45 or unimplemented give nothing
// - Reset: selects all ones, codes all zeros
// - Locked route register writes complete but change nothing; alternate bit still writable
// - Lock changes only after 46h, 57h keys
module rpr_router #(
	parameter logic [rpr_pkg::NUM_PINS-1:0] IMPL_MASK = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Peripheral side
	input rpr_pkg::rpr_fout_t fout,
	output logic [rpr_pkg::NUM_IN-1:0] periph_in,
	// Pads
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] bidir_remap_pin_in,
	output logic [rpr_pkg::NUM_BIDIR-1:0] bidir_remap_pin_out,
	output logic [rpr_pkg::NUM_BIDIR-1:0] bidir_remap_pin_oe_n,
	input wire logic [rpr_pkg::NUM_INONLY-1:0] input_only_remap_pin,
	output logic fixed_spi_clock_pin,
	output logic fixed_spi_clock_pin_oe_n,
	// Per-pin control from port logic
	input wire logic [rpr_pkg::NUM_PINS-1:0] analog_en,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] pin_direction,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] gp_out,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] fixed_drive,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] fixed_out
);
	import rpr_pkg::*;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic [11:0] reg_addr(input logic [11:0] base, input int idx);
		return base + 12'(idx * 4);
	endfunction : reg_addr

	function automatic logic [31:0] pack2(input logic [5:0] f0, input logic [5:0] f1);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[FLD0_LSB +: FLD_W] = f0;
		w[FLD1_LSB +: FLD_W] = f1;
		return w;
	endfunction : pack2

	// Invalid or analog-gated selects read as low
	function automatic logic route_in(input logic [5:0] sel,
		input logic [NUM_PINS-1:0] pins, input logic [NUM_PINS-1:0] ana);
		logic v;
		v = 1'b0;
		if (sel <= MAX_PIN_SEL) begin
			v = pins[sel] & IMPL_MASK[sel] & ~ana[sel];
		end
		return v;
	endfunction : route_in

	// Returns {routed, level}
	function automatic logic [1:0] route_out(input logic [5:0] code, input rpr_fout_t f);
		logic [1:0] r;
		r = 2'b00;
		case (code)
			CODE_CMP1: r = {1'b1, f.comparator_one_out};
			CODE_CMP2: r = {1'b1, f.comparator_two_out};
			CODE_UART_ONE_TRANSMIT: r = {1'b1, f.uart_one_transmit};
			CODE_UART_ONE_REQUEST_SEND: r = {1'b1, f.uart_one_request_send};
			CODE_UART_TWO_TRANSMIT: r = {1'b1, f.uart_two_transmit};
			CODE_UART_TWO_REQUEST_SEND: r = {1'b1, f.uart_two_request_send};
			CODE_SPI1_DO: r = {1'b1, f.spi1_data_out};
			CODE_SPI1_CK: r = {1'b1, f.spi1_clock_out};
			CODE_SPI1_SS: r = {1'b1, f.spi1_select_out};
			CODE_SPI2_DO: r = {1'b1, f.spi2_data_out};
			CODE_SPI2_CK: r = {1'b1, f.spi2_clock_out};
			CODE_SPI2_SS: r = {1'b1, f.spi2_select_out};
			CODE_OC1: r = {1'b1, f.compare_output_one};
			default: r = 2'b00;
		endcase
		return r;
	endfunction : route_out

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// Always zero wait state; only word transfers are meaningful,
	// hsize is not checked and haddr[31:12] is not decoded.
	logic wr_pend_q;
	logic [11:0] addr_q;
	wire logic take = hsel & htrans[1] & hready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			addr_q <= 12'h000;
		end else begin
			wr_pend_q <= take & hwrite;
			if (take) begin
				addr_q <= haddr[11:0];
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------
	// Lock and unlock sequence
	// ----------------------------------------
	logic lock_q;
	logic alt_q;
	rpr_unlock_t unl_q;
	rpr_unlock_t unl_d;
	wire logic osc_wr = wr_pend_q & (addr_q == OSC_ADDR);
	wire logic alt_wr = wr_pend_q & (addr_q == ALT_ADDR);
	wire logic [7:0] key = hwdata[7:0];
	wire logic key1 = key == UNLOCK_KEY1;
	wire logic key2 = key == UNLOCK_KEY2;
	// Route registers take writes only while unlocked
	wire logic wr_ok = wr_pend_q & ~lock_q;

	// Any other value written breaks the sequence; 46h written again after 46h keeps the first key
	always_comb begin
		unl_d = unl_q;
		if (osc_wr) begin
			unique case (unl_q)
				UNL_IDLE: unl_d = key1 ? UNL_KEY1 : UNL_IDLE;
				UNL_KEY1: unl_d = key2 ? UNL_OPEN : (key1 ? UNL_KEY1 : UNL_IDLE);
				UNL_OPEN: unl_d = UNL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unl_q <= UNL_IDLE;
			lock_q <= 1'b0;
			alt_q <= 1'b0;
		end else begin
			unl_q <= unl_d;
			if (osc_wr && unl_q == UNL_OPEN) begin
				lock_q <= hwdata[LOCK_BIT];
			end
			if (alt_wr) begin
				alt_q <= hwdata[ALT_SPI_BIT];
			end
		end
	end

	// ----------------------------------------
	// Route registers
	// ----------------------------------------
	logic [5:0] in_sel_q [NUM_IN];
	logic [5:0] out_code_q [NUM_BIDIR];

	for (genvar r = 0; r < NUM_IN_REGS; r++) begin : g_in_reg
		wire logic hit = wr_ok & (addr_q == reg_addr(IN_BASE, r));
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				in_sel_q[2*r] <= IN_SEL_RST;
				in_sel_q[2*r+1] <= IN_SEL_RST;
			end else if (hit) begin
				in_sel_q[2*r] <= hwdata[FLD0_LSB +: FLD_W];
				in_sel_q[2*r+1] <= hwdata[FLD1_LSB +: FLD_W];
			end
		end
	end

	for (genvar r = 0; r < NUM_OUT_REGS; r++) begin : g_out_reg
		wire logic hit = wr_ok & (addr_q == reg_addr(OUT_BASE, r));
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				out_code_q[2*r] <= OUT_CODE_RST;
				out_code_q[2*r+1] <= OUT_CODE_RST;
			end else if (hit) begin
				out_code_q[2*r] <= hwdata[FLD0_LSB +: FLD_W];
				out_code_q[2*r+1] <= hwdata[FLD1_LSB +: FLD_W];
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Reads see the address of the current data phase, so a write
	// just before a read of the same word is already visible.
	logic [31:0] rdata;

	always_comb begin
		rdata = 32'h0000_0000;
		for (int r = 0; r < NUM_IN_REGS; r++) begin
			if (addr_q == reg_addr(IN_BASE, r)) begin
				rdata = pack2(in_sel_q[2*r], in_sel_q[2*r+1]);
			end
		end
		for (int r = 0; r < NUM_OUT_REGS; r++) begin
			if (addr_q == reg_addr(OUT_BASE, r)) begin
				rdata = pack2(out_code_q[2*r], out_code_q[2*r+1]);
			end
		end
		if (addr_q == ALT_ADDR) begin
			rdata[ALT_SPI_BIT] = alt_q;
		end
		if (addr_q == OSC_ADDR) begin
			rdata[LOCK_BIT] = lock_q;
		end
	end

	assign hrdata = rdata;

	// ----------------------------------------
	// Pin input synchronisers
	// ----------------------------------------
	wire logic [NUM_PINS-1:0] pin_raw = {input_only_remap_pin, bidir_remap_pin_in};
	logic [NUM_PINS-1:0] pin_s1_q;
	logic [NUM_PINS-1:0] pin_s2_q;
	logic [NUM_PINS-1:0] pin_s3_q;
	logic [NUM_PINS-1:0] pin_q;
	// A level is taken only once stages two and three agree
	wire logic [NUM_PINS-1:0] pin_d = (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			pin_q <= '0;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q <= pin_d;
		end
	end

	// ----------------------------------------
	// Input routing
	// ----------------------------------------
	// Input selection never touches the pad drivers.
	logic [NUM_IN-1:0] periph_in_q;

	for (genvar i = 0; i < NUM_IN; i++) begin : g_in_route
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				periph_in_q[i] <= 1'b0;
			end else begin
				periph_in_q[i] <= route_in(in_sel_q[i], pin_q, analog_en);
			end
		end
	end

	assign periph_in = periph_in_q;

	// ----------------------------------------
	// Output routing
	// ----------------------------------------
	// Drive enable comes from fixed peripherals, routed outputs or
	// the pin direction; routed inputs play no part in it.
	logic [NUM_BIDIR-1:0] pin_out_q;
	logic [NUM_BIDIR-1:0] pin_oe_n_q;

	for (genvar p = 0; p < NUM_BIDIR; p++) begin : g_out_route
		wire logic [1:0] ro = route_out(out_code_q[p], fout);
		wire logic out_d = fixed_drive[p] ? fixed_out[p] :
			(ro[1] ? ro[0] : gp_out[p]);
		wire logic drive = fixed_drive[p] | ro[1] | ~pin_direction[p];
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				pin_out_q[p] <= 1'b0;
				pin_oe_n_q[p] <= 1'b1;
			end else begin
				pin_out_q[p] <= out_d;
				pin_oe_n_q[p] <= ~drive;
			end
		end
	end

	assign bidir_remap_pin_out = pin_out_q;
	assign bidir_remap_pin_oe_n = pin_oe_n_q;

	// ----------------------------------------
	// Alternate fixed spi1 clock pin
	// ----------------------------------------
	// Nothing stops a route code also selecting the spi1 clock while
	// this path is on; software must avoid that.
	logic alt_out_q;
	logic alt_oe_n_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_out_q <= 1'b0;
			alt_oe_n_q <= 1'b1;
		end else begin
			alt_out_q <= alt_q & fout.spi1_clock_out;
			alt_oe_n_q <= ~alt_q;
		end
	end

	assign fixed_spi_clock_pin = alt_out_q;
	assign fixed_spi_clock_pin_oe_n = alt_oe_n_q;

endmodule : rpr_router

// ---- dv/rpr_far_model.sv ----
// Far-side model: routable peripheral outputs and pad environment
module rpr_far_model (
	// Clock, reset and stall
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	// Peripheral outputs and pad levels
	output rpr_pkg::rpr_fout_t fout,
	output logic [31:0] pad_in,
	output logic [13:0] pad_only,
	// Router pad drive
	input wire logic [31:0] pin_out,
	input wire logic [31:0] oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import rpr_pkg::*;
	logic [58:0] st_q;
	// Pattern moves every cycle; hold freezes it so routed levels can settle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else if (!hold) begin
			st_q <= {st_q[57:0], st_q[58] ~^ st_q[38]};
		end
	end
	assign fout = st_q[12:0];
	assign pad_only = st_q[26:13];
	// A driven pad reads back the router's own level
	assign pad_in = (~oe_n & pin_out) | (oe_n & st_q[58:27]);
endmodule : rpr_far_model

// ---- dv/rpr_router_checker.sv ----
// Port-level assertions of the remappable pin router
module rpr_router_checker (
	// Clock, reset and bus
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Routing
	input rpr_pkg::rpr_fout_t fout,
	input wire logic [rpr_pkg::NUM_IN-1:0] periph_in,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] bidir_remap_pin_out,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] bidir_remap_pin_oe_n,
	input wire logic fixed_spi_clock_pin,
	input wire logic fixed_spi_clock_pin_oe_n,
	input wire logic [rpr_pkg::NUM_PINS-1:0] analog_en,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] pin_direction,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] fixed_drive,
	input wire logic [rpr_pkg::NUM_BIDIR-1:0] fixed_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import rpr_pkg::*;
	logic up_q;
	logic [2:0] ana_q;
	// Outputs lag their causes by one edge, so the first edge after reset is skipped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			up_q <= 1'b0;
			ana_q <= 3'h0;
		end else begin
			up_q <= 1'b1;
			ana_q <= !(&analog_en) ? 3'h0 : (ana_q == 3'h7) ? ana_q : ana_q + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_xfer;
		hsel && htrans[1] && hready;
	endsequence
	property p_okay;
		s_xfer |=> hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not okay");
	property p_rsvd;
		(hrdata & 32'hFFFF_C080) == 32'h0000_0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("unused read bits set");
	property p_rst;
		!up_q |-> periph_in == '0 && bidir_remap_pin_out == '0 && &bidir_remap_pin_oe_n;
	endproperty
	a_rst: assert property (p_rst) else $error("routing active after reset");
	property p_fixed;
		up_q |-> ((bidir_remap_pin_out ^ $past(fixed_out)) & $past(fixed_drive)) == '0
			&& (bidir_remap_pin_oe_n & $past(fixed_drive)) == '0;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed output lost");
	property p_dir;
		up_q |-> (bidir_remap_pin_oe_n & ~$past(pin_direction)) == '0;
	endproperty
	a_dir: assert property (p_dir) else $error("output pin not driven");
	property p_alt_off;
		fixed_spi_clock_pin_oe_n |-> !fixed_spi_clock_pin;
	endproperty
	a_alt_off: assert property (p_alt_off) else $error("idle fixed pin high");
	property p_alt_on;
		up_q && !fixed_spi_clock_pin_oe_n |-> fixed_spi_clock_pin == $past(fout.spi1_clock_out);
	endproperty
	a_alt_on: assert property (p_alt_on) else $error("fixed pin lost clock");
	property p_analog;
		ana_q == 3'h7 |-> periph_in == '0;
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin reached input");
endmodule : rpr_router_checker

bind rpr_router rpr_router_checker rpr_router_checker_inst (.clk, .rst_n, .hsel, .htrans,
	.hready, .hrdata, .hreadyout, .hresp, .fout, .periph_in, .bidir_remap_pin_out,
	.bidir_remap_pin_oe_n, .fixed_spi_clock_pin, .fixed_spi_clock_pin_oe_n, .analog_en,
	.pin_direction, .fixed_drive, .fixed_out);

// ---- dv/rpr_router_tb.sv ----
// Self-checking bench of the remappable pin router
module rpr_router_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rpr_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hold = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
	logic hreadyout, hresp, fixed_spi_clock_pin, fixed_spi_clock_pin_oe_n;
	rpr_fout_t fout;
	logic [NUM_IN-1:0] periph_in;
	logic [NUM_BIDIR-1:0] bidir_remap_pin_in, bidir_remap_pin_out, bidir_remap_pin_oe_n;
	logic [NUM_BIDIR-1:0] pin_direction = '1, gp_out = '0, fixed_drive = '0, fixed_out = '0;
	logic [NUM_INONLY-1:0] input_only_remap_pin;
	logic [NUM_PINS-1:0] analog_en = '0;
	int sel[NUM_IN] = '{default: 63};
	int code[NUM_BIDIR] = '{default: 0};
	int lk = 0, ust = 0, alt = 0, num_errors = 0, n_tests = 0;
	// Key bytes: lock, broken order while locked, then unlock
	logic [7:0] keys [11] = '{8'h46, 8'h57, 8'h40, 8'h00, 8'h57, 8'h46, 8'h00, 8'h57, 8'h46,
		8'h57, 8'h00};
	initial forever #2.5 clk = ~clk;
	rpr_router rpr_router_inst (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .fout, .periph_in,
		.bidir_remap_pin_in, .bidir_remap_pin_out, .bidir_remap_pin_oe_n,
		.input_only_remap_pin, .fixed_spi_clock_pin, .fixed_spi_clock_pin_oe_n, .analog_en,
		.pin_direction, .gp_out, .fixed_drive, .fixed_out);
	rpr_far_model rpr_far_model_inst (.clk, .rst_n, .hold, .fout, .pad_in(bidir_remap_pin_in),
		.pad_only(input_only_remap_pin), .pin_out(bidir_remap_pin_out),
		.oe_n(bidir_remap_pin_oe_n));
	// --------
	// Checking and bus tasks
	// --------
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 40);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			print_verdict();
		end
	endtask : wait_rdy
	task automatic xfer(input logic w, input int a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= 32'(a);
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask : xfer
	function automatic logic [31:0] rexp(input int a);
		int o;
		o = a - OUT_BASE;
		if (a < 4 * NUM_IN_REGS) return 32'(sel[a / 2 + 1] * 256 + sel[a / 2]);
		if (o >= 0 && o < 4 * NUM_OUT_REGS) return 32'(code[o / 2 + 1] * 256 + code[o / 2]);
		if (a == ALT_ADDR) return 32'(alt);
		if (a == OSC_ADDR) return 32'(lk * 64);
		return 32'h0000_0000;
	endfunction : rexp
	// Write, update the reference, then read back
	task automatic acc(input int a, input logic [31:0] d);
		logic [31:0] q;
		int o;
		o = a - OUT_BASE;
		xfer(1'b1, a, d, q);
		if (a < 4 * NUM_IN_REGS && lk == 0) begin
			sel[a / 2] = d[5:0];
			sel[a / 2 + 1] = d[13:8];
		end
		if (o >= 0 && o < 4 * NUM_OUT_REGS && lk == 0) begin
			code[o / 2] = d[5:0];
			code[o / 2 + 1] = d[13:8];
		end
		if (a == ALT_ADDR) alt = d[0];
		if (a == OSC_ADDR && ust == 2) begin
			lk = d[6];
			ust = 0;
		end else if (a == OSC_ADDR) begin
			ust = (d[7:0] == UNLOCK_KEY1) ? 1 : (ust == 1 && d[7:0] == UNLOCK_KEY2) ? 2 : 0;
		end
		xfer(1'b0, a, 32'h0000_0000, q);
		chk(q, rexp(a));
	endtask : acc
	task automatic check_pins();
		logic [NUM_IN-1:0] ei;
		logic [31:0] eo, ee;
		logic [NUM_PINS-1:0] pads;
		int c;
		logic v;
		pads = {input_only_remap_pin, bidir_remap_pin_in};
		for (int i = 0; i < NUM_IN; i++) ei[i] = sel[i] <= 45 && !analog_en[sel[i]] && pads[sel[i]];
		for (int p = 0; p < NUM_BIDIR; p++) begin
			c = code[p];
			v = (c >= 1 && c <= 12) || c == 18;
			eo[p] = fixed_drive[p] ? fixed_out[p] : v ? fout[c == 18 ? 0 : 13 - c] : gp_out[p];
			ee[p] = !(fixed_drive[p] || v || !pin_direction[p]);
		end
		chk(periph_in, ei);
		chk(bidir_remap_pin_out, eo);
		chk(bidir_remap_pin_oe_n, ee);
	endtask : check_pins
	// --------
	// Main sequence
	// --------
	initial begin
		void'($urandom(32'hd4b9_1430));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a <= 260; a += 4) begin
			xfer(1'b0, a, 32'h0000_0000, r);
			chk(r, rexp(a));
		end
		check_pins();
		for (int n = 0; n < 4; n++) begin
			for (int i = 0; i < NUM_IN_REGS; i++) acc(4 * i, $urandom());
			for (int i = 0; i < NUM_OUT_REGS; i++) begin
				r = $urandom();
				r[5:0] = 6'($urandom_range(19));
				r[13:8] = 6'($urandom_range(19));
				acc(OUT_BASE + 4 * i, r);
			end
			analog_en <= (n == 1) ? '1 : NUM_PINS'({$urandom(), $urandom()});
			pin_direction <= $urandom();
			gp_out <= $urandom();
			fixed_drive <= $urandom() & $urandom() & $urandom();
			fixed_out <= $urandom();
			hold <= 1'b0;
			repeat (20) @(posedge clk);
			hold <= 1'b1;
			repeat (10) @(posedge clk);
			check_pins();
		end
		// Lock, refused writes, broken key order, then unlock again
		foreach (keys[i]) begin
			acc(OSC_ADDR, {24'h00_0000, keys[i]});
			if (i == 2 || i == 7) begin
				acc(IN_BASE + 4, 32'h0000_2A15);
				acc(OUT_BASE + 4, 32'h0000_0807);
			end
		end
		acc(IN_BASE, 32'h0000_0101);
		for (int i = 0; i < NUM_OUT_REGS; i++) acc(OUT_BASE + 4 * i, 32'h0000_0000);
		acc(ALT_ADDR, 32'h0000_0001);
		hold <= 1'b0;
		repeat (20) @(posedge clk);
		hold <= 1'b1;
		repeat (3) @(posedge clk);
		chk({fixed_spi_clock_pin, fixed_spi_clock_pin_oe_n}, {fout.spi1_clock_out, 1'b0});
		check_pins();
		acc(ALT_ADDR, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk({fixed_spi_clock_pin, fixed_spi_clock_pin_oe_n}, 2'b01);
		print_verdict();
	end
endmodule : rpr_router_tb
